/* core/atha_pkg.sv */
/*
 * Constants, carriers and helpers shared by the address table host access block.
 * Assumes a byte-wide register port holding the page offsets below and one core clock.
 */
// Contract
// - start bit seven with direction, device clears it
// - both bin entries always move together
// - read locates bin by key, returns both
// - write overwrites whole bin regardless of valid
// - addresses kept in canonical bit order
// - optional vlan key joins the hash
// - bit 63 marks a valid stored address
// - learning only into invalid, non-static locations
// - static entries skip learning and aging
// - age bit set on use, cleared by aging
// - unicast priority and port code layout
// - multicast entries carry a thirteen bit mask; the entry keeps only bits 54:48
// - scan start bit clears after whole table
// - result read advances the scan
// - ready flag set on hit, read clears
// - scan returns entries valid or static
// - result register flag and vlan layout
// - result port code or multicast mask
// - extension register holds priority and mii
package atha_pkg;
    localparam int BIN_CNT = 512;
    localparam int ENTRY_CNT = 1024;
    localparam int BIN_W = 9;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] LAST_IDX = 10'h3ff;

    localparam logic [7:0] OFS_ACC_CTRL = 8'h00;
    localparam logic [7:0] OFS_MAC_KEY = 8'h02;
    localparam logic [7:0] OFS_VLAN_KEY = 8'h08;
    localparam logic [7:0] OFS_ENTRY0 = 8'h10;
    localparam logic [7:0] OFS_ENTRY1 = 8'h18;
    localparam logic [7:0] OFS_SCAN_CTRL = 8'h20;
    localparam logic [7:0] OFS_SCAN_RES = 8'h24;
    localparam logic [7:0] OFS_SCAN_LAST = 8'h2b;
    localparam logic [7:0] OFS_SCAN_EXT = 8'h2c;

    localparam int BIT_START = 7;
    localparam int BIT_DIR = 0;
    localparam int BIT_READY = 0;
    localparam int BIT_MCAST = 40;
    localparam logic [3:0] VLAN_KEY_MASK = 4'hf;
    localparam logic [63:0] UC_KEEP_MASK = 64'hf80f_ffff_ffff_ffff;
    localparam logic [63:0] MC_KEEP_MASK = 64'hf87f_ffff_ffff_ffff;
    localparam logic [3:0] UC_PORT_MII = 4'h8;

    typedef struct packed {
        logic valid;
        logic pinned;
        logic recent;
        logic [1:0] prio;
        logic [6:0] rsvd;
        logic [3:0] port;
        logic [47:0] addr;
    } atha_entry_s;

    typedef struct packed {
        logic [47:0] addr;
        logic [3:0] port;
        logic [3:0] vid;
    } atha_learn_s;

    // fold address and optional vlan into a bin number
    function automatic logic [BIN_W-1:0] atha_hash(input logic [47:0] a,
                                                   input logic [11:0] v,
                                                   input logic en);
        logic [BIN_W-1:0] x;
        x = a[8:0] ^ a[17:9] ^ a[26:18] ^ a[35:27] ^ a[44:36] ^ {6'h00, a[47:45]};
        if (en) begin
            x = x ^ v[8:0] ^ {6'h00, v[11:9]};
        end
        return x;
    endfunction

    // strip reserved bits; multicast keeps the wider port mask
    function automatic logic [63:0] atha_clean(input logic [63:0] e);
        return e & (e[BIT_MCAST] ? MC_KEEP_MASK : UC_KEEP_MASK);
    endfunction
endpackage

/* core/atha_top.sv */
/*
 * Address table with its host access registers, learning, aging and sequential scan.
 * Assumes register strobes are single-cycle, synchronous to clk_sys, one byte per access.
 */
`timescale 1ns/1ps
module atha_top import atha_pkg::*; (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // configuration held elsewhere
    input wire logic vlan_plus_addr_hash,
    input wire logic [7:0] vlan_upper_fixed,
    // learning and aging engines
    input wire logic learn_req,
    input wire atha_learn_s learn_info,
    input wire logic age_tick
);
    typedef enum logic [1:0] {SC_IDLE, SC_RUN, SC_HOLD} atha_scan_e;

    logic [63:0] tbl_q [ENTRY_CNT];
    logic [3:0] vid_q [ENTRY_CNT];
    logic [47:0] mac_key_q;
    logic [3:0] vlan_key_q;
    logic [63:0] entry_q [2];
    logic acc_start_q;
    logic dir_q;
    atha_scan_e scan_q;
    logic [IDX_W-1:0] scan_idx_q;
    logic [63:0] result_q;
    logic [7:0] ext_q;
    logic ready_q;
    logic learn_pend_q;
    atha_learn_s learn_hold_q;
    logic sweep_busy_q;
    logic [IDX_W-1:0] sweep_idx_q;
    logic [7:0] rdata_q;

    logic [BIN_W-1:0] host_bin;
    logic host_wr_commit;
    logic lrn_go;
    atha_learn_s lrn;
    logic [BIN_W-1:0] lrn_bin;
    atha_entry_s le0;
    atha_entry_s le1;
    logic lrn_hit0;
    logic lrn_hit1;
    atha_entry_s sw_e;
    atha_entry_s sc_e;
    logic [2:0] wbyte;
    logic [63:0] ent0_clean;
    logic [63:0] ent1_clean;

    assign ent0_clean = atha_clean(entry_q[0]);
    assign ent1_clean = atha_clean(entry_q[1]);
    assign host_bin = atha_hash(mac_key_q, {vlan_upper_fixed, vlan_key_q},
                                vlan_plus_addr_hash);
    assign host_wr_commit = acc_start_q & ~dir_q;
    assign lrn_go = learn_pend_q | learn_req;
    assign lrn = learn_pend_q ? learn_hold_q : learn_info;
    assign lrn_bin = atha_hash(lrn.addr, {vlan_upper_fixed, lrn.vid}, vlan_plus_addr_hash);
    assign le0 = atha_entry_s'(tbl_q[{lrn_bin, 1'b0}]);
    assign le1 = atha_entry_s'(tbl_q[{lrn_bin, 1'b1}]);
    assign lrn_hit0 = le0.valid & (le0.addr == lrn.addr);
    assign lrn_hit1 = le1.valid & (le1.addr == lrn.addr);
    assign sw_e = atha_entry_s'(tbl_q[sweep_idx_q]);
    assign sc_e = atha_entry_s'(tbl_q[scan_idx_q]);
    assign wbyte = reg_addr[2:0];

    // host registers and access command
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mac_key_q <= '0;
            vlan_key_q <= '0;
            entry_q[0] <= '0;
            entry_q[1] <= '0;
            acc_start_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (ce) begin
            if (acc_start_q) begin
                acc_start_q <= 1'b0;
                if (dir_q) begin
                    entry_q[0] <= atha_clean(tbl_q[{host_bin, 1'b0}]);
                    entry_q[1] <= atha_clean(tbl_q[{host_bin, 1'b1}]);
                end
            end else if (reg_wr) begin
                // while busy the key and entries take no host writes
                if (reg_addr == OFS_ACC_CTRL) begin
                    acc_start_q <= reg_wdata[BIT_START];
                    dir_q <= reg_wdata[BIT_DIR];
                end
                if (reg_addr >= OFS_MAC_KEY && reg_addr < OFS_VLAN_KEY) begin
                    mac_key_q[8*(3'(reg_addr - OFS_MAC_KEY)) +: 8] <= reg_wdata;
                end
                if (reg_addr == OFS_VLAN_KEY) begin
                    vlan_key_q <= reg_wdata[3:0] & VLAN_KEY_MASK;
                end
                if (reg_addr >= OFS_ENTRY0 && reg_addr < OFS_ENTRY1) begin
                    entry_q[0][8*wbyte +: 8] <= reg_wdata;
                end
                if (reg_addr >= OFS_ENTRY1 && reg_addr < OFS_SCAN_CTRL) begin
                    entry_q[1][8*wbyte +: 8] <= reg_wdata;
                end
            end
        end
    end

    // learn requests that collide with a host write wait one slot
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            learn_pend_q <= 1'b0;
            learn_hold_q <= '0;
        end else if (ce) begin
            if (host_wr_commit) begin
                if (learn_req && !learn_pend_q) begin
                    learn_pend_q <= 1'b1;
                    learn_hold_q <= learn_info;
                end
            end else if (learn_pend_q && learn_req) begin
                learn_hold_q <= learn_info;
            end else begin
                learn_pend_q <= 1'b0;
            end
        end
    end

    // aging sweep walks every entry once per tick
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sweep_busy_q <= 1'b0;
            sweep_idx_q <= '0;
        end else if (ce) begin
            if (!sweep_busy_q) begin
                sweep_busy_q <= age_tick;
                sweep_idx_q <= '0;
            end else if (!host_wr_commit && !lrn_go) begin
                sweep_idx_q <= sweep_idx_q + 1'b1;
                if (sweep_idx_q == LAST_IDX) begin
                    sweep_busy_q <= 1'b0;
                end
            end
        end
    end

    // table storage: host write first, then learning, then aging
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < ENTRY_CNT; i++) begin
                tbl_q[i] <= '0;
                vid_q[i] <= '0;
            end
        end else if (ce) begin
            if (host_wr_commit) begin
                tbl_q[{host_bin, 1'b0}] <= atha_clean(entry_q[0]);
                tbl_q[{host_bin, 1'b1}] <= atha_clean(entry_q[1]);
                vid_q[{host_bin, 1'b0}] <= vlan_key_q;
                vid_q[{host_bin, 1'b1}] <= vlan_key_q;
            end else if (lrn_go) begin
                if (lrn_hit0 || lrn_hit1) begin
                    // a known non-static station refreshes its age and port
                    if (lrn_hit0 && !le0.pinned) begin
                        tbl_q[{lrn_bin, 1'b0}][61] <= 1'b1;
                        tbl_q[{lrn_bin, 1'b0}][51:48] <= lrn.port;
                    end else if (lrn_hit1 && !le1.pinned) begin
                        tbl_q[{lrn_bin, 1'b1}][61] <= 1'b1;
                        tbl_q[{lrn_bin, 1'b1}][51:48] <= lrn.port;
                    end
                end else if (!le0.valid && !le0.pinned) begin
                    tbl_q[{lrn_bin, 1'b0}] <= {3'b101, 13'h0000, lrn.addr} |
                                              {12'h000, lrn.port, 48'h0};
                    vid_q[{lrn_bin, 1'b0}] <= lrn.vid;
                end else if (!le1.valid && !le1.pinned) begin
                    tbl_q[{lrn_bin, 1'b1}] <= {3'b101, 13'h0000, lrn.addr} |
                                              {12'h000, lrn.port, 48'h0};
                    vid_q[{lrn_bin, 1'b1}] <= lrn.vid;
                end
            end else if (sweep_busy_q && sw_e.valid && !sw_e.pinned) begin
                // two passes: first clears age, second one frees the entry
                if (sw_e.recent) begin
                    tbl_q[sweep_idx_q][61] <= 1'b0;
                end else begin
                    tbl_q[sweep_idx_q][63] <= 1'b0;
                end
            end
        end
    end

    // sequential scan; stalls on each hit until the result is read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scan_q <= SC_IDLE;
            scan_idx_q <= '0;
            result_q <= '0;
            ext_q <= '0;
            ready_q <= 1'b0;
        end else if (ce) begin
            unique case (scan_q)
                SC_IDLE: begin
                    if (reg_wr && reg_addr == OFS_SCAN_CTRL && reg_wdata[BIT_START]) begin
                        scan_q <= SC_RUN;
                        scan_idx_q <= '0;
                    end
                end
                SC_RUN: begin
                    if (sc_e.valid || sc_e.pinned) begin
                        result_q <= '0;
                        result_q[63:61] <= {sc_e.valid, sc_e.pinned, sc_e.recent};
                        result_q[47:0] <= sc_e.addr;
                        if (sc_e.addr[BIT_MCAST]) begin
                            result_q[52:48] <= tbl_q[scan_idx_q][52:48];
                        end else begin
                            result_q[56:53] <= vid_q[scan_idx_q];
                            result_q[51:48] <= sc_e.port;
                        end
                        ext_q <= {5'h00, sc_e.addr[BIT_MCAST] & tbl_q[scan_idx_q][53],
                                  sc_e.prio};
                        ready_q <= 1'b1;
                        scan_q <= SC_HOLD;
                    end else if (scan_idx_q == LAST_IDX) begin
                        scan_q <= SC_IDLE;
                    end else begin
                        scan_idx_q <= scan_idx_q + 1'b1;
                    end
                end
                SC_HOLD: begin
                    if (reg_rd && reg_addr == OFS_SCAN_LAST) begin
                        ready_q <= 1'b0;
                        if (scan_idx_q == LAST_IDX) begin
                            scan_q <= SC_IDLE;
                        end else begin
                            scan_idx_q <= scan_idx_q + 1'b1;
                            scan_q <= SC_RUN;
                        end
                    end
                end
            endcase
        end
    end

    // registered read data, reserved bytes and bits read zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                if (reg_addr == OFS_ACC_CTRL) begin
                    rdata_q <= {acc_start_q, 6'h00, dir_q};
                end else if (reg_addr >= OFS_MAC_KEY && reg_addr < OFS_VLAN_KEY) begin
                    rdata_q <= mac_key_q[8*(3'(reg_addr - OFS_MAC_KEY)) +: 8];
                end else if (reg_addr == OFS_VLAN_KEY) begin
                    rdata_q <= {4'h0, vlan_key_q};
                end else if (reg_addr >= OFS_ENTRY0 && reg_addr < OFS_ENTRY1) begin
                    rdata_q <= ent0_clean[8*wbyte +: 8];
                end else if (reg_addr >= OFS_ENTRY1 && reg_addr < OFS_SCAN_CTRL) begin
                    rdata_q <= ent1_clean[8*wbyte +: 8];
                end else if (reg_addr == OFS_SCAN_CTRL) begin
                    rdata_q <= {scan_q != SC_IDLE, 6'h00, ready_q};
                end else if (reg_addr >= OFS_SCAN_RES && reg_addr <= OFS_SCAN_LAST) begin
                    rdata_q <= result_q[8*(3'(reg_addr - OFS_SCAN_RES)) +: 8];
                end else if (reg_addr == OFS_SCAN_EXT) begin
                    rdata_q <= ext_q;
                end
            end
        end
    end

    assign reg_rdata = rdata_q;
endmodule

/* verification/atha_props.sv */
/*
 * Port checker for the address table host access top.
 * Assumes it is bound onto atha_top and sees only its ports.
 */
`timescale 1ns/1ps
module atha_props import atha_pkg::*; (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // side inputs
    input wire logic vlan_plus_addr_hash,
    input wire logic [7:0] vlan_upper_fixed,
    input wire logic learn_req,
    input wire atha_learn_s learn_info,
    input wire logic age_tick
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // host writes other than scan control are refused in the single busy cycle after a table access start
    logic acc_busy_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc_busy_q <= 1'b0;
        end else if (ce) begin
            acc_busy_q <= reg_wr && reg_addr == OFS_ACC_CTRL && reg_wdata[BIT_START] && !acc_busy_q;
        end
    end

    idle_zero_a: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero without a read");
    acc_done_a: assert property (ce && reg_wr && reg_addr == OFS_ACC_CTRL && reg_wdata[7]
        ##1 ce ##1 ce && reg_rd && reg_addr == OFS_ACC_CTRL |=> !reg_rdata[BIT_START])
        else $error("access start bit still set");
    acc_rsvd_a: assert property (ce && reg_rd && reg_addr == OFS_ACC_CTRL |=> reg_rdata[6:1] == 6'h00)
        else $error("access control reserved bits set");
    vlan_key_a: assert property (ce && reg_wr && reg_addr == OFS_VLAN_KEY && !acc_busy_q
        ##1 ce && reg_rd && reg_addr == OFS_VLAN_KEY
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f))
        else $error("vlan key readback wrong");
    scan_rsvd_a: assert property (ce && reg_rd && reg_addr == OFS_SCAN_CTRL |=> reg_rdata[6:1] == 6'h00)
        else $error("scan control reserved bits set");
    res_rsvd_a: assert property (ce && reg_rd && reg_addr == OFS_SCAN_LAST |=> reg_rdata[4:1] == 4'h0)
        else $error("result reserved bits set");
    ext_rsvd_a: assert property (ce && reg_rd && reg_addr == OFS_SCAN_EXT |=> reg_rdata[7:3] == 5'h00)
        else $error("extension reserved bits set");
    unmapped_rd_a: assert property (ce && reg_rd && (reg_addr == 8'h01 || reg_addr > OFS_SCAN_EXT)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    scan_busy_a: assert property (ce && reg_wr && reg_addr == OFS_SCAN_CTRL && reg_wdata[7]
        ##1 ce && reg_rd && reg_addr == OFS_SCAN_CTRL |=> reg_rdata[BIT_START])
        else $error("scan busy not shown");

    access_start_c: cover property (ce && reg_wr && reg_addr == OFS_ACC_CTRL && reg_wdata[7]);
    result_advance_c: cover property (ce && reg_rd && reg_addr == OFS_SCAN_LAST);
    age_sweep_c: cover property (ce && age_tick);
endmodule

bind atha_top atha_props i_atha_props (.clk_sys, .sys_rst, .ce, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .vlan_plus_addr_hash, .vlan_upper_fixed, .learn_req, .learn_info,
    .age_tick);

/* verification/atha_top_tb.sv */
/*
 * Self-checking bench: bin write and read, busy refusal, sequential scan, aging.
 * Assumes the package and the checker bind are compiled before it.
 */
`timescale 1ns/1ps
module atha_top_tb import atha_pkg::*; ;
    localparam logic [47:0] MAC0 = 48'h0012_3456_789a;
    // raw entries carry reserved bits set; they must come back cleared
    localparam logic [63:0] E0_RAW = 64'hbff8_0012_3456_789a;
    localparam logic [63:0] E1_RAW = 64'h4ff3_0000_aabb_ccdd;
    localparam logic [63:0] E0_EXP = 64'hb808_0012_3456_789a;
    localparam logic [63:0] E1_EXP = 64'h4803_0000_aabb_ccdd;
    localparam logic [63:0] E0_AGED = 64'h1808_0012_3456_789a;
    localparam logic [63:0] R0 = 64'ha008_0012_3456_789a;
    localparam logic [63:0] R1 = 64'h4003_0000_aabb_ccdd;

    logic clk_sys;
    logic sys_rst;
    logic ce;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic age_tick;
    logic learn_req;
    atha_learn_s learn_info;
    int n_mismatch;
    int samples_checked;

    // learning reuses the host key, so it lands in the bin already known
    atha_top i_atha_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .vlan_plus_addr_hash(1'b0), .vlan_upper_fixed(8'h00), .learn_req(learn_req),
        .learn_info(learn_info), .age_tick(age_tick));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus cycle: strobes stand for exactly one enabled edge
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        #1;
        d = reg_rdata;
    endtask

    task automatic w64(input logic [7:0] a, input logic [63:0] v);
        for (int i = 0; i < 8; i++) begin
            op(1'b1, 1'b0, a + 8'(i), v[8*i +: 8]);
        end
        op(1'b0, 1'b0, a, 8'h00);
    endtask

    // low bytes first so the advancing byte of the result is read last
    task automatic r64(input logic [7:0] a, output logic [63:0] v);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            rd(a + 8'(i), b);
            v[8*i +: 8] = b;
        end
    endtask

    task automatic poll(input logic [7:0] a, input int bitn, input logic val);
        logic [7:0] b;
        for (int i = 0; i < 1200; i++) begin
            rd(a, b);
            if (b[bitn] === val) begin
                return;
            end
        end
        n_mismatch++;
        $display("Error poll %h expected %b seen timeout", a, val);
        finish_test();
    endtask

    // the entry write lands in the busy cycle and must be dropped
    task automatic readbin(input logic [63:0] e0, input logic [63:0] e1);
        logic [7:0] b;
        logic [63:0] v;
        op(1'b1, 1'b0, OFS_ACC_CTRL, 8'h81);
        op(1'b1, 1'b0, OFS_ENTRY0, 8'h55);
        poll(OFS_ACC_CTRL, 7, 1'b0);
        rd(OFS_ACC_CTRL, b);
        chk("acc_ctrl", b, 8'h01);
        r64(OFS_ENTRY0, v);
        chk("entry_first", v, e0);
        r64(OFS_ENTRY1, v);
        chk("entry_second", v, e1);
    endtask

    task automatic t_access();
        logic [7:0] b;
        w64(OFS_MAC_KEY, {16'h0000, MAC0});
        op(1'b1, 1'b0, OFS_VLAN_KEY, 8'hf0);
        rd(OFS_VLAN_KEY, b);
        chk("vlan_key", b, 8'h00);
        w64(OFS_ENTRY0, E0_RAW);
        w64(OFS_ENTRY1, E1_RAW);
        op(1'b1, 1'b0, OFS_ACC_CTRL, 8'h80);
        poll(OFS_ACC_CTRL, 7, 1'b0);
        w64(OFS_ENTRY0, 64'h0);
        w64(OFS_ENTRY1, 64'h0);
        readbin(E0_EXP, E1_EXP);
    endtask

    task automatic t_scan();
        logic [7:0] b;
        logic [63:0] v;
        op(1'b1, 1'b0, OFS_SCAN_CTRL, 8'h80);
        poll(OFS_SCAN_CTRL, 0, 1'b1);
        rd(OFS_SCAN_EXT, b);
        chk("ext_first", b, 8'h03);
        r64(OFS_SCAN_RES, v);
        chk("result_first", v, R0);
        poll(OFS_SCAN_CTRL, 0, 1'b1);
        rd(OFS_SCAN_EXT, b);
        chk("ext_second", b, 8'h01);
        r64(OFS_SCAN_RES, v);
        chk("result_second", v, R1);
        poll(OFS_SCAN_CTRL, 7, 1'b0);
        rd(OFS_SCAN_CTRL, b);
        chk("scan_ctrl", b, 8'h00);
        rd(8'h2d, b);
        chk("unmapped", b, 8'h00);
    endtask

    // two sweeps: first clears the recent flag, second drops the dynamic entry
    task automatic t_age();
        repeat (2) begin
            @(posedge clk_sys);
            age_tick <= 1'b1;
            @(posedge clk_sys);
            age_tick <= 1'b0;
            repeat (1100) @(posedge clk_sys);
        end
        readbin(E0_AGED, E1_EXP);
        @(posedge clk_sys);
        learn_req <= 1'b1;
        learn_info <= '{addr: MAC0, port: 4'h2, vid: 4'h0};
        @(posedge clk_sys);
        learn_req <= 1'b0;
        readbin(64'ha002_0012_3456_789a, E1_EXP);
    endtask

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        age_tick = 1'b0;
        learn_req = 1'b0;
        learn_info = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_access();
        t_scan();
        t_age();
        finish_test();
    end
endmodule
